// *** src/asbl_pkg.sv ***
/*
 * Package for the host-side controller of an asynchronous 16-bit SRAM
 * with two byte lanes: widths, timing figures, states and pin carrier.
 * Assumes a single 50 MHz core clock.
 */
package asbl_pkg;

	// -------------------------------------------------------------------
	// geometry
	// -------------------------------------------------------------------
	localparam int ADDR_W  = 18;
	localparam int DATA_W  = 16;
	localparam int LANE_W  = 8;

	// -------------------------------------------------------------------
	// timing: figures in ns, counts derived from the clock rate
	// -------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	// slowest grade cycle time, so any grade of the part is safe
	localparam int T_CYCLE_NS    = 15;
	localparam int T_WE_PULSE_NS = 12;
	localparam int T_ACCESS_NS   = 15;
	localparam int CYC_W         = 4;
	localparam logic [CYC_W-1:0] CYC_CYCLE =
		CYC_W'((T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CYC_W-1:0] CYC_WE_PULSE =
		CYC_W'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// one extra cycle so read data is sampled after the access time
	localparam logic [CYC_W-1:0] CYC_ACCESS =
		CYC_W'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
	localparam logic [CYC_W-1:0] CYC_ONE = 4'h1;

	// -------------------------------------------------------------------
	// states and pin carrier
	// -------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_WAIT,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_END,
		ST_RECOVER
	} asbl_state_e;

	typedef struct packed {
		logic              chip_sel_n;
		logic              out_drive_n;
		logic              write_strobe_n;
		logic              low_byte_select_n;
		logic              high_byte_select_n;
		logic [ADDR_W-1:0] word_address;
	} asbl_pins_s;

	localparam asbl_pins_s PINS_IDLE = '{
		chip_sel_n: 1'b1, out_drive_n: 1'b1, write_strobe_n: 1'b1,
		low_byte_select_n: 1'b1, high_byte_select_n: 1'b1,
		word_address: '0};

endpackage

// *** src/asbl_host.sv ***
/*
 * Host controller driving an asynchronous 16-bit SRAM with byte lanes.
 * A user request (read or write, address, data, byte mask) is turned
 * into one strobe-timed pin cycle. Assumes the memory is a plain
 * asynchronous part and user inputs are synchronous to i_core_clk.
 */
module asbl_host (
	input  wire logic                         i_core_clk,
	input  wire logic                         i_nrst,
	input  wire logic                         i_req_valid,
	input  wire logic                         i_req_write,
	input  wire logic [asbl_pkg::ADDR_W-1:0]  i_req_addr,
	input  wire logic [asbl_pkg::DATA_W-1:0]  i_req_wdata,
	input  wire logic [1:0]                   i_req_lanes,
	input  wire logic                         i_retain_req,
	input  wire logic [asbl_pkg::DATA_W-1:0]  i_data_pins,
	output logic                              o_req_ready,
	output logic                              o_rd_valid,
	output logic [asbl_pkg::DATA_W-1:0]       o_rd_data,
	output logic                              o_retain_ok,
	output asbl_pkg::asbl_pins_s              o_pins,
	output logic [asbl_pkg::DATA_W-1:0]       o_data_pins,
	output logic                              o_data_pins_oe
);

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	asbl_pkg::asbl_state_e             state_ff, nxt_state;
	logic [asbl_pkg::CYC_W-1:0]        cnt_ff, nxt_cnt;
	asbl_pkg::asbl_pins_s              pins_ff, nxt_pins;
	logic [asbl_pkg::DATA_W-1:0]       wdata_ff, nxt_wdata;
	logic                              oe_ff, nxt_oe;
	logic [asbl_pkg::DATA_W-1:0]       rdata_ff, nxt_rdata;
	logic                              rvalid_ff, nxt_rvalid;
	logic                              ready_ff, nxt_ready;
	logic                              retain_ff, nxt_retain;

	// -------------------------------------------------------------------
	// next-state logic
	// -------------------------------------------------------------------
	always_comb begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_pins   = pins_ff;
		nxt_wdata  = wdata_ff;
		nxt_oe     = oe_ff;
		nxt_rdata  = rdata_ff;
		nxt_rvalid = 1'b0;
		nxt_ready  = 1'b0;
		nxt_retain = 1'b0;
		if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - asbl_pkg::CYC_ONE;
		end
		unique case (state_ff)
			asbl_pkg::ST_IDLE: begin
				// deselected while idle, so retention may start at once
				nxt_pins   = asbl_pkg::PINS_IDLE;
				nxt_oe     = 1'b0;
				nxt_retain = i_retain_req;
				nxt_ready  = !i_retain_req;
				if (i_req_valid && ready_ff && !i_retain_req) begin
					nxt_ready                  = 1'b0;
					// address and lanes settle with chip select falling
					nxt_pins.word_address      = i_req_addr;
					nxt_pins.chip_sel_n        = 1'b0;
					nxt_pins.low_byte_select_n = !i_req_lanes[0];
					nxt_pins.high_byte_select_n = !i_req_lanes[1];
					nxt_wdata                  = i_req_wdata;
					if (i_req_write) begin
						// output drive held off so the device never drives
						nxt_state = asbl_pkg::ST_WR_SETUP;
					end else begin
						nxt_pins.out_drive_n = 1'b0;
						nxt_cnt   = asbl_pkg::CYC_ACCESS;
						nxt_state = asbl_pkg::ST_RD_WAIT;
					end
				end
			end
			asbl_pkg::ST_RD_WAIT: begin
				// write strobe stays high throughout the read
				if (cnt_ff == asbl_pkg::CYC_ONE) begin
					nxt_rdata = i_data_pins;
					// a lane left unselected is floating: read it as zero
					if (pins_ff.low_byte_select_n) begin
						nxt_rdata[asbl_pkg::LANE_W-1:0] = '0;
					end
					if (pins_ff.high_byte_select_n) begin
						nxt_rdata[asbl_pkg::DATA_W-1:asbl_pkg::LANE_W] = '0;
					end
					nxt_rvalid = 1'b1;
					nxt_pins   = asbl_pkg::PINS_IDLE;
					nxt_cnt    = asbl_pkg::CYC_ONE;
					nxt_state  = asbl_pkg::ST_RECOVER;
				end
			end
			asbl_pkg::ST_WR_SETUP: begin
				// strobe falls a cycle after address: zero address setup met
				nxt_pins.write_strobe_n = 1'b0;
				nxt_oe    = 1'b1;
				nxt_cnt   = asbl_pkg::CYC_WE_PULSE;
				nxt_state = asbl_pkg::ST_WR_PULSE;
			end
			asbl_pkg::ST_WR_PULSE: begin
				if (cnt_ff == asbl_pkg::CYC_ONE) begin
					// strobe rises alone and ends the write
					nxt_pins.write_strobe_n = 1'b1;
					nxt_state = asbl_pkg::ST_WR_END;
				end
			end
			asbl_pkg::ST_WR_END: begin
				// data held one cycle past the terminating edge
				nxt_oe    = 1'b0;
				nxt_pins  = asbl_pkg::PINS_IDLE;
				nxt_cnt   = asbl_pkg::CYC_ONE;
				nxt_state = asbl_pkg::ST_RECOVER;
			end
			asbl_pkg::ST_RECOVER: begin
				if (cnt_ff <= asbl_pkg::CYC_ONE) begin
					nxt_state = asbl_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = asbl_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			state_ff  <= asbl_pkg::ST_IDLE;
			cnt_ff    <= '0;
			pins_ff   <= asbl_pkg::PINS_IDLE;
			wdata_ff  <= '0;
			oe_ff     <= 1'b0;
			rdata_ff  <= '0;
			rvalid_ff <= 1'b0;
			ready_ff  <= 1'b0;
			retain_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			pins_ff   <= nxt_pins;
			wdata_ff  <= nxt_wdata;
			oe_ff     <= nxt_oe;
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
			ready_ff  <= nxt_ready;
			retain_ff <= nxt_retain;
		end
	end

	assign o_pins         = pins_ff;
	assign o_data_pins    = wdata_ff;
	assign o_data_pins_oe = oe_ff;
	assign o_rd_data      = rdata_ff;
	assign o_rd_valid     = rvalid_ff;
	assign o_req_ready    = ready_ff;
	assign o_retain_ok    = retain_ff;

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	sequence s_wr_open;
		!pins_ff.chip_sel_n && !pins_ff.write_strobe_n;
	endsequence

	a_read_strobe_high: assert property (@(posedge i_core_clk)
		disable iff (!i_nrst)
		!pins_ff.out_drive_n |-> pins_ff.write_strobe_n)
		else $error("write strobe low during read");

	a_no_bus_fight: assert property (@(posedge i_core_clk)
		disable iff (!i_nrst)
		oe_ff |-> pins_ff.out_drive_n)
		else $error("host drives data while device output enabled");

	a_wr_pulse_len: assert property (@(posedge i_core_clk)
		disable iff (!i_nrst)
		$rose(!pins_ff.write_strobe_n) |-> s_wr_open [*1] ##1
		pins_ff.write_strobe_n)
		else $error("write pulse length wrong");

	a_data_hold: assert property (@(posedge i_core_clk)
		disable iff (!i_nrst)
		$rose(pins_ff.write_strobe_n) |-> oe_ff && $stable(wdata_ff))
		else $error("write data not held past strobe rise");

	a_strobe_first: assert property (@(posedge i_core_clk)
		disable iff (!i_nrst)
		$rose(pins_ff.write_strobe_n) |-> !pins_ff.chip_sel_n
		##1 pins_ff.chip_sel_n)
		else $error("write end ordering wrong");

	a_addr_stable: assert property (@(posedge i_core_clk)
		disable iff (!i_nrst)
		!pins_ff.chip_sel_n && !$past(pins_ff.chip_sel_n)
		|-> $stable(pins_ff.word_address))
		else $error("address changed while selected");

	a_read_returns: assert property (@(posedge i_core_clk)
		disable iff (!i_nrst)
		$fell(pins_ff.out_drive_n) |-> ##2 pins_ff.chip_sel_n
		##0 rvalid_ff)
		else $error("read did not complete in time");

	a_retain_desel: assert property (@(posedge i_core_clk)
		disable iff (!i_nrst)
		retain_ff |-> pins_ff.chip_sel_n && !oe_ff)
		else $error("retention granted while selected");

endmodule

// *** dv/asbl_sram_model.sv ***
/*
 * Behavioural model of the 16-bit two-lane static RAM on the pins.
 * Assumes the bench resolves the shared data wire from both drivers.
 */
module asbl_sram_model (
	input  wire asbl_pkg::asbl_pins_s i_pins,
	input  wire logic [15:0]          i_data,
	output logic [15:0]               o_data,
	output logic [1:0]                o_drive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [logic [17:0]];
	logic [15:0] word;
	logic [15:0] nw;
	logic [15:0] flt = 16'h5aa5;
	logic        rd;
	// ----------------------------------------------------------------
	// read side
	// ----------------------------------------------------------------
	// floating lanes wander, so stale data can never be mistaken
	always #7 flt = ~flt;
	always @* begin
		rd = !i_pins.chip_sel_n && !i_pins.out_drive_n
			&& i_pins.write_strobe_n;
		o_drive = {rd && !i_pins.high_byte_select_n,
			rd && !i_pins.low_byte_select_n};
		word = mem.exists(i_pins.word_address) ?
			mem[i_pins.word_address] : 16'h0000;
		o_data[7:0] = o_drive[0] ? word[7:0] : flt[7:0];
		o_data[15:8] = o_drive[1] ? word[15:8] : flt[15:8];
	end
	// ----------------------------------------------------------------
	// write side: stored when the select and strobe overlap ends
	// ----------------------------------------------------------------
	always @(posedge (i_pins.chip_sel_n | i_pins.write_strobe_n)) begin
		if (!$isunknown(i_pins.word_address)) begin
			nw = mem.exists(i_pins.word_address) ?
				mem[i_pins.word_address] : 16'h0000;
			if (!i_pins.low_byte_select_n)
				nw[7:0] = i_data[7:0];
			if (!i_pins.high_byte_select_n)
				nw[15:8] = i_data[15:8];
			mem[i_pins.word_address] = nw;
		end
	end
endmodule

// *** dv/test_asbl_host.sv ***
/*
 * Self-checking bench for the SRAM host controller with a RAM model.
 * Assumes the controller takes one request at a time on a ready handshake.
 */
module test_asbl_host;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk = 1'b0;
	logic                 nrst = 1'b0;
	logic                 valid = 1'b0, wr = 1'b0, retain = 1'b0;
	logic [17:0]          addr = 18'h00000;
	logic [15:0]          wdata = 16'h0000, rdata, pins_in, sdat, hdat;
	logic [1:0]           lanes = 2'h0, sdrv;
	logic                 ready, rvalid, ret_ok, oe;
	asbl_pkg::asbl_pins_s pins;
	int                   fail_count = 0, n_checks = 0, cyc = 0;
	// ----------------------------------------------------------------
	// clock, wire resolution, watchdog
	// ----------------------------------------------------------------
	initial forever #10 clk = ~clk;
	assign pins_in = oe ? hdat : sdat;
	asbl_host i_asbl_host (.i_core_clk(clk), .i_nrst(nrst),
		.i_req_valid(valid), .i_req_write(wr), .i_req_addr(addr),
		.i_req_wdata(wdata), .i_req_lanes(lanes), .i_retain_req(retain),
		.i_data_pins(pins_in), .o_req_ready(ready), .o_rd_valid(rvalid),
		.o_rd_data(rdata), .o_retain_ok(ret_ok), .o_pins(pins),
		.o_data_pins(hdat), .o_data_pins_oe(oe));
	asbl_sram_model i_asbl_sram_model (.i_pins(pins), .i_data(pins_in),
		.o_data(sdat), .o_drive(sdrv));
	task automatic chk16(input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: exp %h got %h", $time, e, g);
		end
	endtask
	task automatic chk1(input logic e, input logic g);
		chk16({15'h0000, e}, {15'h0000, g});
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			test_done();
		end else if (oe === 1'b1) begin
			chk1(1'b0, |sdrv);
		end
	end
	// ----------------------------------------------------------------
	// request driver and scenarios
	// ----------------------------------------------------------------
	task automatic req(input logic w, input logic [17:0] a,
		input logic [15:0] d, input logic [1:0] l, output logic [15:0] q);
		int n;
		n = 0;
		valid <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= d;
		lanes <= l;
		do begin
			@(posedge clk);
			n++;
		end while (ready !== 1'b1 && n < 40);
		chk1(1'b1, ready);
		valid <= 1'b0;
		// let an edge pass so the next call never re-raises valid at once
		if (w)
			@(posedge clk);
		q = 16'h0000;
		n = 0;
		while (!w && rvalid !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (!w)
			q = rdata;
		chk1(1'b0, n == 20);
	endtask
	task automatic t_rd(input logic [17:0] a, input logic [1:0] l,
		input logic [15:0] e);
		logic [15:0] q;
		req(1'b0, a, 16'h0000, l, q);
		chk16(e, q);
	endtask
	task automatic t_wr(input logic [17:0] a, input logic [15:0] d,
		input logic [1:0] l);
		logic [15:0] q;
		req(1'b1, a, d, l, q);
	endtask
	task automatic t_retain();
		retain <= 1'b1;
		repeat (12) @(posedge clk);
		chk1(1'b1, ret_ok);
		chk1(1'b1, pins.chip_sel_n);
		chk1(1'b0, ready);
		retain <= 1'b0;
		@(posedge clk);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_wr(18'h3ffff, 16'ha55a, 2'h3);
		t_rd(18'h3ffff, 2'h3, 16'ha55a);
		t_wr(18'h00000, 16'h1234, 2'h3);
		t_wr(18'h00000, 16'habcd, 2'h2);
		t_rd(18'h00000, 2'h3, 16'hab34);
		t_rd(18'h00000, 2'h2, 16'hab00);
		t_wr(18'h00000, 16'h99ef, 2'h1);
		t_rd(18'h00000, 2'h1, 16'h00ef);
		t_retain();
		t_rd(18'h3ffff, 2'h3, 16'ha55a);
		test_done();
	end
endmodule
